// >>> hdl/awm_pkg.sv
// constants shared by the write-multiple command block
package awm_pkg;
  // ****************************************************************
  // opcodes and block count
  // ****************************************************************
  localparam logic [7:0] CMD_WR_MULT = 8'hc5;
  localparam logic [7:0] CMD_WR_MULT_NE = 8'hcd;
  localparam logic [7:0] MULT_BLOCK = 8'h01;
  // ****************************************************************
  // task file bit positions
  // ****************************************************************
  localparam int ST_BSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_BBK = 7;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  localparam int DH_LBA = 6;
  localparam int DH_DRV = 4;
  // drive ready and seek complete set, everything else clear
  localparam logic [7:0] ST_READY = 8'h50;
  // bits that must read zero after an accepted command
  localparam logic [7:0] ER_ZERO_MASK = 8'h6f;
  // ****************************************************************
  // address layout {head/lba27:24, cyl hi, cyl lo, sector}
  // ****************************************************************
  localparam int ADDR_W = 28;
  localparam int HEAD_LSB = 24;
  localparam int CYL_LSB = 8;
  typedef enum logic [1:0] {S_IDLE, S_XFER, S_PROG} awm_state_e;
endpackage : awm_pkg

// >>> hdl/awm_write_multiple.sv
// write-multiple command interpreter with its host data fifo
`timescale 1ns/1ps
// Notes on behaviour
// - Write-multiple is taken only after a set-multiple command has succeeded and enabled multiple mode.
// - With multiple mode off, the command sets the abort error bit and ends with no data moved.
// - When enabled it acts like a sector write, a whole block moving with no handshake inside the block.
// - The block count comes from the latest set-multiple and only a count of one is accepted.
// - Opcode C5h written to the command register starts the command using the loaded task file.
// - Opcode CDh does exactly what C5h does, enable check, transfer and reporting included.
// - At the end status shows busy 0, ready 1, fault 0, seek done 1, index 0, others as the outcome says.
// - At the end the address registers hold the last sector written correctly, or the start address when no sector was written.
// - After an unrecoverable error the sector count holds the sectors not written.
// - A start address outside the card's range sets ID-not-found and ends the command.

module awm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [LW-1:0] level;
  } awm_fifo_s;
  awm_fifo_s st_ff;
  awm_fifo_s nxt_st;
  logic push;
  logic pop;

  assign o_in_ready = st_ff.level != LW'(DEPTH);
  assign o_out_valid = st_ff.level != '0;
  assign o_out_data = st_ff.mem[st_ff.rd];
  assign o_level = st_ff.level;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = i_in_data;
      nxt_st.wr = (st_ff.wr == PW'(DEPTH-1)) ? '0 : st_ff.wr + PW'(1);
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == PW'(DEPTH-1)) ? '0 : st_ff.rd + PW'(1);
    end
    nxt_st.level = st_ff.level + LW'(push) - LW'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : awm_fifo

module awm_write_multiple #(
  parameter int WORDS_PER_SECTOR = 256,
  parameter int FIFO_DEPTH = 4,
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS = 16,
  parameter int CYLINDERS = 16383
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CMD_WR,
  input wire logic [7:0] I_CMD,
  input wire logic [7:0] I_DRV_HEAD,
  input wire logic [7:0] I_CYL_HI,
  input wire logic [7:0] I_CYL_LO,
  input wire logic [7:0] I_SEC_NUM,
  input wire logic [7:0] I_SEC_CNT,
  input wire logic I_SETMULT_DONE,
  input wire logic [7:0] I_SETMULT_CNT,
  input wire logic [27:0] I_MAX_LBA,
  input wire logic [15:0] I_HDATA,
  input wire logic I_HDATA_VALID,
  output logic O_HDATA_READY,
  output logic O_SEC_START,
  output logic [27:0] O_SEC_ADDR,
  output logic O_SEC_LBA,
  output logic [15:0] O_WDATA,
  output logic O_WDATA_VALID,
  input wire logic I_WDATA_READY,
  input wire logic I_SEC_DONE,
  input wire logic I_SEC_ERR,
  output logic [7:0] O_STATUS,
  output logic [7:0] O_ERROR,
  output logic [7:0] O_DRV_HEAD,
  output logic [7:0] O_CYL_HI,
  output logic [7:0] O_CYL_LO,
  output logic [7:0] O_SEC_NUM,
  output logic [7:0] O_SEC_CNT,
  output logic O_MULT_EN,
  output logic O_DONE
);
  localparam int AW = awm_pkg::ADDR_W;
  localparam int WW = $clog2(WORDS_PER_SECTOR);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  typedef struct packed {
    awm_pkg::awm_state_e state;
    logic en;
    logic lba;
    logic drv;
    logic [AW-1:0] addr;
    logic [AW-1:0] good;
    logic [8:0] rem;
    logic [WW-1:0] words;
    logic hready;
    logic sec_start;
    logic done;
    logic [7:0] status;
    logic [7:0] error;
  } awm_top_s;
  awm_top_s st_ff;
  awm_top_s nxt_st;
  logic push;
  logic pop;
  logic fifo_in_ready;
  logic [LW-1:0] level;
  logic [LW-1:0] level_nxt;
  logic cmd_hit;
  logic [AW-1:0] start;
  logic start_bad;

  // ****************************************************************
  // host data path
  // ****************************************************************
  // ready is registered, so it is only raised when a word fits even with no drain
  awm_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_in_data(I_HDATA),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .o_out_data(O_WDATA),
    .o_out_valid(O_WDATA_VALID),
    .i_out_ready(I_WDATA_READY),
    .o_level(level)
  );
  assign push = st_ff.hready && I_HDATA_VALID;
  assign pop = O_WDATA_VALID && I_WDATA_READY;
  assign level_nxt = level + LW'(push) - LW'(pop);

  // ****************************************************************
  // command decode and address checks
  // ****************************************************************
  // features register has no port at all, nothing here depends on it
  assign cmd_hit = I_CMD_WR && (I_CMD == awm_pkg::CMD_WR_MULT || I_CMD == awm_pkg::CMD_WR_MULT_NE);
  assign start = {I_DRV_HEAD[3:0], I_CYL_HI, I_CYL_LO, I_SEC_NUM};

  always_comb begin
    if (I_DRV_HEAD[awm_pkg::DH_LBA]) begin
      start_bad = start > I_MAX_LBA;
    end else begin
      start_bad = I_SEC_NUM == 8'h00 || 32'(I_SEC_NUM) > SECTORS_PER_TRACK
        || 32'(I_DRV_HEAD[3:0]) >= HEADS || 32'({I_CYL_HI, I_CYL_LO}) >= CYLINDERS;
    end
  end

  // chs wraps sector to 1, then head, then cylinder
  function automatic logic [AW-1:0] next_addr(input logic lba, input logic [AW-1:0] a);
    logic [3:0] hd;
    logic [15:0] cy;
    logic [7:0] sc;
    hd = a[AW-1:awm_pkg::HEAD_LSB];
    cy = a[awm_pkg::HEAD_LSB-1:awm_pkg::CYL_LSB];
    sc = a[awm_pkg::CYL_LSB-1:0];
    if (lba) begin
      next_addr = a + AW'(1);
    end else begin
      if (32'(sc) >= SECTORS_PER_TRACK) begin
        sc = 8'h01;
        if (32'(hd) >= HEADS - 1) begin
          hd = 4'h0;
          cy = cy + 16'h0001;
        end else begin
          hd = hd + 4'h1;
        end
      end else begin
        sc = sc + 8'h01;
      end
      next_addr = {hd, cy, sc};
    end
  endfunction : next_addr

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sec_start = 1'b0;
    nxt_st.done = 1'b0;
    if (I_SETMULT_DONE) begin
      nxt_st.en = I_SETMULT_CNT == awm_pkg::MULT_BLOCK;
    end
    case (st_ff.state)
      awm_pkg::S_IDLE: begin
        if (cmd_hit) begin
          nxt_st.lba = I_DRV_HEAD[awm_pkg::DH_LBA];
          nxt_st.drv = I_DRV_HEAD[awm_pkg::DH_DRV];
          nxt_st.addr = start;
          nxt_st.good = start;
          nxt_st.rem = (I_SEC_CNT == 8'h00) ? 9'h100 : {1'b0, I_SEC_CNT};
          nxt_st.words = '0;
          nxt_st.error = 8'h00;
          if (!st_ff.en) begin
            nxt_st.error[awm_pkg::ER_ABRT] = 1'b1;
            nxt_st.status = awm_pkg::ST_READY | 8'h01;
            nxt_st.done = 1'b1;
          end else if (start_bad) begin
            nxt_st.error[awm_pkg::ER_IDNF] = 1'b1;
            nxt_st.status = awm_pkg::ST_READY | 8'h01;
            nxt_st.done = 1'b1;
          end else begin
            nxt_st.status = awm_pkg::ST_READY;
            nxt_st.status[awm_pkg::ST_DRQ] = 1'b1;
            nxt_st.sec_start = 1'b1;
            nxt_st.state = awm_pkg::S_XFER;
          end
        end
      end
      awm_pkg::S_XFER: begin
        // one block is one sector, so drq spans exactly one sector of words
        if (push) begin
          nxt_st.words = st_ff.words + WW'(1);
          if (st_ff.words == WW'(WORDS_PER_SECTOR-1)) begin
            nxt_st.status = awm_pkg::ST_READY;
            nxt_st.status[awm_pkg::ST_BSY] = 1'b1;
            nxt_st.state = awm_pkg::S_PROG;
          end
        end
      end
      awm_pkg::S_PROG: begin
        if (I_SEC_DONE) begin
          if (I_SEC_ERR) begin
            // failed sector stays counted, address keeps the last good one
            nxt_st.error[awm_pkg::ER_BBK] = 1'b1;
            nxt_st.status = awm_pkg::ST_READY | 8'h01;
            nxt_st.done = 1'b1;
            nxt_st.state = awm_pkg::S_IDLE;
          end else begin
            nxt_st.good = st_ff.addr;
            nxt_st.addr = next_addr(st_ff.lba, st_ff.addr);
            nxt_st.rem = st_ff.rem - 9'h001;
            nxt_st.words = '0;
            nxt_st.status = awm_pkg::ST_READY;
            if (st_ff.rem == 9'h001) begin
              nxt_st.done = 1'b1;
              nxt_st.state = awm_pkg::S_IDLE;
            end else begin
              nxt_st.status[awm_pkg::ST_DRQ] = 1'b1;
              nxt_st.sec_start = 1'b1;
              nxt_st.state = awm_pkg::S_XFER;
            end
          end
        end
      end
      default: begin
        nxt_st.state = awm_pkg::S_IDLE;
      end
    endcase
    nxt_st.hready = nxt_st.state == awm_pkg::S_XFER && level_nxt < LW'(FIFO_DEPTH);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      st_ff <= '0;
      st_ff.status <= awm_pkg::ST_READY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_HDATA_READY = st_ff.hready;
  assign O_SEC_START = st_ff.sec_start;
  assign O_SEC_ADDR = st_ff.addr;
  assign O_SEC_LBA = st_ff.lba;
  assign O_STATUS = st_ff.status;
  assign O_ERROR = st_ff.error;
  assign O_DRV_HEAD = {1'b0, st_ff.lba, 1'b0, st_ff.drv, st_ff.good[AW-1:awm_pkg::HEAD_LSB]};
  assign O_CYL_HI = st_ff.good[awm_pkg::HEAD_LSB-1:16];
  assign O_CYL_LO = st_ff.good[15:awm_pkg::CYL_LSB];
  assign O_SEC_NUM = st_ff.good[awm_pkg::CYL_LSB-1:0];
  assign O_SEC_CNT = st_ff.rem[7:0];
  assign O_MULT_EN = st_ff.en;
  assign O_DONE = st_ff.done;

  // ****************************************************************
  // checks
  // ****************************************************************
  abort_when_off_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st_ff.state == awm_pkg::S_IDLE && cmd_hit && !st_ff.en) |=>
    O_DONE && O_ERROR == 8'h04 && !O_STATUS[awm_pkg::ST_DRQ] && !O_SEC_START)
    else $error("disabled command did not abort");
  enable_only_one_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    I_SETMULT_DONE |=> O_MULT_EN == ($past(I_SETMULT_CNT) == 8'h01))
    else $error("multiple mode enable does not follow block count");
  alias_starts_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st_ff.state == awm_pkg::S_IDLE && I_CMD_WR && I_CMD == awm_pkg::CMD_WR_MULT_NE && st_ff.en && !start_bad) |=>
    O_SEC_START && O_STATUS == 8'h58)
    else $error("legacy opcode not handled like write multiple");
  end_status_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_DONE |-> (O_STATUS & 8'hf6) == 8'h50 && O_STATUS[awm_pkg::ST_ERR] == (O_ERROR != 8'h00))
    else $error("completion status wrong");
  error_clean_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (O_DONE && !O_ERROR[awm_pkg::ER_ABRT]) |-> (O_ERROR & awm_pkg::ER_ZERO_MASK) == 8'h00)
    else $error("forbidden error bit set");
  idnf_start_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st_ff.state == awm_pkg::S_IDLE && cmd_hit && st_ff.en && start_bad) |=>
    O_DONE && O_ERROR == 8'h10 ##1 !O_SEC_START)
    else $error("out of range start not rejected");
  remaining_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st_ff.state == awm_pkg::S_PROG && I_SEC_DONE && I_SEC_ERR) |=>
    O_SEC_CNT == $past(st_ff.rem[7:0]) && O_ERROR[awm_pkg::ER_BBK] && $stable(O_SEC_NUM))
    else $error("remaining count or address wrong after error");
  last_good_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st_ff.state == awm_pkg::S_PROG && I_SEC_DONE && !I_SEC_ERR) |=>
    {O_DRV_HEAD[3:0], O_CYL_HI, O_CYL_LO, O_SEC_NUM} == $past(st_ff.addr))
    else $error("last good address not reported");
  ready_in_drq_a:
  assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_HDATA_READY |-> O_STATUS[awm_pkg::ST_DRQ] && !O_STATUS[awm_pkg::ST_BSY] && fifo_in_ready)
    else $error("data taken outside a data request");
endmodule : awm_write_multiple

// >>> verification/awm_far_model.sv
// far-side model: host data source and sector engine sink
`timescale 1ns/1ps
module awm_far_model #(
  parameter int WORDS = 8
) (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_slow,
  input wire logic [7:0] i_fail_sec,
  output logic [15:0] o_hdata,
  output logic o_hdata_valid,
  input wire logic i_hdata_ready,
  input wire logic [15:0] i_wdata,
  input wire logic i_wdata_valid,
  output logic o_wdata_ready,
  output logic o_sec_done,
  output logic o_sec_err,
  output logic [15:0] o_words,
  output logic [15:0] o_bad
);
  logic [15:0] sent;
  logic [7:0] sec;
  logic ph;
  // ********
  // host side
  // ********
  // words carry their index so a lost or repeated word shows at the sink
  assign o_hdata_valid = !i_clear;
  assign o_hdata = i_clear ? ~(16'ha000 + sent) : 16'ha000 + sent;
  // ********
  // engine side
  // ********
  assign o_wdata_ready = !i_clear && !(i_slow && ph);
  always @(posedge i_clk) begin
    o_sec_done <= 1'b0;
    o_sec_err <= 1'b0;
    if (i_clear) begin
      sent <= 16'h0;
      o_words <= 16'h0;
      o_bad <= 16'h0;
      sec <= 8'h0;
      ph <= 1'b0;
    end else begin
      ph <= !ph;
      if (o_hdata_valid && i_hdata_ready) begin
        sent <= sent + 16'h1;
      end
      if (i_wdata_valid && o_wdata_ready) begin
        if (i_wdata !== 16'ha000 + o_words) begin
          o_bad <= o_bad + 16'h1;
        end
        o_words <= o_words + 16'h1;
        if ((o_words + 16'h1) % 16'(WORDS) == 16'h0) begin
          o_sec_done <= 1'b1;
          o_sec_err <= (sec == i_fail_sec);
          sec <= sec + 8'h1;
        end
      end
    end
  end
endmodule : awm_far_model

// >>> verification/testbench.sv
// self-checking bench for the write-multiple command block
`timescale 1ns/1ps
module testbench;
  localparam int WPS = 8;
  logic clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, sm_done = 1'b0, clr = 1'b1, slow = 1'b0;
  logic [7:0] cmd = 8'h0, dh = 8'h0, ch = 8'h0, cl = 8'h0, sn = 8'h0, cnt = 8'h0, sm_cnt = 8'h0;
  logic [7:0] fail = 8'hff;
  logic [15:0] hd, wd, words, bad;
  logic hv, hr, sst, slba, wv, wr, sd, se, men, done;
  logic [27:0] saddr, first_addr;
  logic [7:0] st, er, odh, och, ocl, osn, ocnt;
  int error_cnt = 0, samples_checked = 0, cycles = 0, starts = 0;
  initial forever #50 clk = ~clk;
  awm_write_multiple #(.WORDS_PER_SECTOR(WPS)) dut_u (.I_REF_CLK(clk), .I_RESET(rst), .I_CMD_WR(cmd_wr),
    .I_CMD(cmd), .I_DRV_HEAD(dh), .I_CYL_HI(ch), .I_CYL_LO(cl), .I_SEC_NUM(sn), .I_SEC_CNT(cnt),
    .I_SETMULT_DONE(sm_done), .I_SETMULT_CNT(sm_cnt), .I_MAX_LBA(28'h1ffffff), .I_HDATA(hd),
    .I_HDATA_VALID(hv), .O_HDATA_READY(hr), .O_SEC_START(sst), .O_SEC_ADDR(saddr), .O_SEC_LBA(slba),
    .O_WDATA(wd), .O_WDATA_VALID(wv), .I_WDATA_READY(wr), .I_SEC_DONE(sd), .I_SEC_ERR(se),
    .O_STATUS(st), .O_ERROR(er), .O_DRV_HEAD(odh), .O_CYL_HI(och), .O_CYL_LO(ocl), .O_SEC_NUM(osn),
    .O_SEC_CNT(ocnt), .O_MULT_EN(men), .O_DONE(done));
  awm_far_model #(.WORDS(WPS)) far_u (.i_clk(clk), .i_clear(clr), .i_slow(slow), .i_fail_sec(fail),
    .o_hdata(hd), .o_hdata_valid(hv), .i_hdata_ready(hr), .i_wdata(wd), .i_wdata_valid(wv),
    .o_wdata_ready(wr), .o_sec_done(sd), .o_sec_err(se), .o_words(words), .o_bad(bad));
  // ********
  // monitor and watchdog
  // ********
  always @(posedge clk) begin
    cycles++;
    if (sst === 1'b1) begin
      if (starts == 0) first_addr = saddr;
      starts++;
    end
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ********
  // shared tasks
  // ********
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task set_mult(input logic [7:0] c);
    @(negedge clk);
    sm_done = 1'b1;
    sm_cnt = c;
    @(negedge clk);
    sm_done = 1'b0;
  endtask : set_mult
  // one cycle of clear empties the far side before each command
  task issue(input logic [7:0] op, d, h, l, s, c);
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    starts = 0;
    {cmd, dh, ch, cl, sn, cnt} = {op, d, h, l, s, c};
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask : issue
  task wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(n < 4000, 32'h1);
  endtask : wait_done
  task expect_end(input logic [7:0] s, e, c, input logic [27:0] a);
    check(st, s);
    check(er, e);
    check(ocnt, c);
    check({och, ocl, osn}, a[23:0]);
    check(odh, {1'b0, dh[6], 1'b0, dh[4], a[27:24]});
  endtask : expect_end
  // ********
  // scenarios
  // ********
  task t_abort;
    int n;
    check(st, 8'h50);
    for (int i = 0; i < 2; i++) begin
      issue((i == 0) ? 8'hc5 : 8'hcd, 8'h40, 8'h0, 8'h0, 8'h1, 8'h1);
      wait_done(n);
      // done is already up at the falling edge right after the command edge
      check(n, 32'h0);
      check({er, st}, 16'h0451);
      check(starts, 0);
    end
    set_mult(8'h2);
    issue(8'hc5, 8'h40, 8'h0, 8'h0, 8'h1, 8'h1);
    wait_done(n);
    check(er, 8'h04);
    set_mult(8'h1);
    check(men, 1);
    $display("test abort done");
  endtask : t_abort
  task t_lba;
    int n;
    for (int i = 0; i < 2; i++) begin
      issue((i == 0) ? 8'hc5 : 8'hcd, 8'hf1, 8'h23, 8'h45, 8'h67, 8'h2);
      repeat (3) @(negedge clk);
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      wait_done(n);
      check(starts, 2);
      check(first_addr, 28'h1234567);
      check(slba, 1);
      check({words, bad}, {16'(2 * WPS), 16'h0});
      expect_end(8'h50, 8'h00, 8'h00, 28'h1234568);
    end
    $display("test lba done");
  endtask : t_lba
  task t_fault;
    int n;
    fail = 8'h1;
    issue(8'hc5, 8'h40, 8'h0, 8'h0, 8'h10, 8'h3);
    wait_done(n);
    expect_end(8'h51, 8'h80, 8'h2, 28'h0000010);
    check(er & awm_pkg::ER_ZERO_MASK, 0);
    fail = 8'hff;
    issue(8'hcd, 8'h42, 8'h0, 8'h0, 8'h0, 8'h5);
    wait_done(n);
    expect_end(8'h51, 8'h10, 8'h5, 28'h2000000);
    issue(8'hc5, 8'ha3, 8'h1, 8'h2, 8'h0, 8'h1);
    wait_done(n);
    expect_end(8'h51, 8'h10, 8'h1, 28'h3010200);
    $display("test fault done");
  endtask : t_fault
  task t_chs;
    int n;
    slow = 1'b1;
    issue(8'hc5, 8'ha3, 8'h1, 8'h2, 8'h3f, 8'h2);
    wait_done(n);
    check(first_addr, 28'h301023f);
    check(slba, 0);
    check({words, bad}, {16'(2 * WPS), 16'h0});
    expect_end(8'h50, 8'h00, 8'h00, 28'h4010201);
    slow = 1'b0;
    $display("test chs done");
  endtask : t_chs
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_abort();
    t_lba();
    t_fault();
    t_chs();
    close_out();
  end
endmodule : testbench
